// [rtl/igp_geometry_pipeline.v]
// binning, subsampling, mirroring, area-of-interest crop and row stride padding of a sensor stream
`timescale 1ns/1ps
`include "igp_consts.vh"

// Summary of operation
// - sensor row count is reported, above zero; a line-scan sensor reports one.
// - sensor tap count is readable as an enumerated code.
// - parallel A/D samples per conversion readable as the same enumeration.
// - reduced column maximum computed after column combining and subsampling.
// - reduced row maximum computed after row combining and subsampling.
// - output row holds exactly the programmed width of pixels, width above zero.
// - output frame holds exactly the programmed height of rows, height above zero.
// - crop starts at programmed column start, counted from the origin.
// - crop starts at programmed row start, counted from the origin.
// - first bytes of consecutive output rows lie the larger of row stride and width apart.
// - adjacent column cells are summed into one pixel by the column factor.
// - column factor one means no horizontal combining.
// - adjacent row cells are summed into one pixel by the row factor.
// - row factor one means no vertical combining.
// - columns are subsampled by dropping, keeping the first of each group.
// - column subsample factor one keeps every column.
// - rows are subsampled by dropping, keeping the first of each group.
// - row subsample factor one keeps every row.
// - column mirroring reverses each row before the crop.
// - row mirroring reverses row order before the crop.
// - start values are measured from the upper-left corner of the reduced frame.
module igp_geometry_pipeline #(
	parameter SENS_COLS = 64,
	parameter SENS_ROWS = 48,
	parameter [15:0] SENS_TAPS = `IGP_TAPS_ONE,
	parameter [15:0] ADC_TAPS  = `IGP_TAPS_ONE
) (
	input  wire        clk,
	input  wire        srst,
	input  wire [3:0]  regAddr,
	input  wire [15:0] regWrData,
	input  wire        regWr,
	input  wire        regRd,
	output wire [15:0] regRdData,
	input  wire        inValid,
	input  wire        inFrameStart,
	input  wire [7:0]  inData,
	output wire        inReady,
	output wire        outValid,
	output wire [7:0]  outData,
	output wire        outPad,
	output wire        outRowStart,
	output wire        outFrameEnd,
	input  wire        outReady
);
	localparam        MEMN   = SENS_COLS * SENS_ROWS;
	localparam        IW     = (MEMN > 1) ? $clog2(MEMN) : 1;
	localparam [15:0] SC     = SENS_COLS[15:0];
	localparam [15:0] SR     = SENS_ROWS[15:0];
	localparam [2:0]  ST_IDLE = 3'b001;
	localparam [2:0]  ST_CAP  = 3'b010;
	localparam [2:0]  ST_OUT  = 3'b100;

	// ==========================================================
	// helpers
	// a factor of zero is read as one so nothing divides by zero
	function [15:0] effF;
		input [15:0] f;
		effF = (f == 16'h0000) ? 16'h0001 : f;
	endfunction

	// keeps first of each subsample group, so the count rounds up
	function [15:0] redDim;
		input [15:0] n;
		input [15:0] b;
		input [15:0] d;
		reg   [16:0] q;
		begin
			q = {1'b0, n / b} + {1'b0, d} - 17'h00001;
			redDim = q[15:0] / d;
		end
	endfunction

	// summing saturates rather than wraps
	function [7:0] satAdd;
		input [7:0] a;
		input [7:0] b;
		reg   [8:0] s;
		begin
			s = {1'b0, a} + {1'b0, b};
			satAdd = s[8] ? 8'hff : s[7:0];
		end
	endfunction

	// row-major index; the store holds a full sensor frame so any reduced frame fits
	function [IW-1:0] memIdx;
		input [15:0] r;
		input [15:0] c;
		reg   [31:0] t;
		begin
			t = r * SC + c;
			memIdx = t[IW-1:0];
		end
	endfunction

	// ==========================================================
	// registers
	reg  [7:0]  frameMem [0:MEMN-1];
	reg  [2:0]  state_reg;
	// configuration, written by software and read live
	reg  [1:0]  ctrl_reg;
	reg  [15:0] colBin_reg;
	reg  [15:0] rowBin_reg;
	reg  [15:0] colDec_reg;
	reg  [15:0] rowDec_reg;
	reg  [15:0] aoiCol_reg;
	reg  [15:0] aoiRow_reg;
	reg  [15:0] aoiW_reg;
	reg  [15:0] aoiH_reg;
	reg  [15:0] stride_reg;
	reg         refused_reg;
	reg  [15:0] rdData_reg;
	// capture: sensor position, group phases and reduced position
	reg  [15:0] sCol_reg;
	reg  [15:0] sRow_reg;
	reg  [15:0] cb_reg;
	reg  [15:0] cd_reg;
	reg  [15:0] rCol_reg;
	reg  [15:0] rb_reg;
	reg  [15:0] rd_reg;
	reg  [15:0] rRow_reg;
	reg  [7:0]  hAcc_reg;
	// readout position and the output beat
	reg  [15:0] oCol_reg;
	reg  [15:0] oRow_reg;
	reg         oDone_reg;
	reg         outValid_reg;
	reg         outPad_reg;
	reg         outRowStart_reg;
	reg         outFrameEnd_reg;
	reg  [7:0]  outData_reg;

	// the maxima follow the factors live, so they read back at once
	wire [15:0] cf  = effF(colBin_reg);
	wire [15:0] rf  = effF(rowBin_reg);
	wire [15:0] cs  = effF(colDec_reg);
	wire [15:0] rs  = effF(rowDec_reg);
	wire [15:0] wMax = redDim(SC, cf, cs);
	wire [15:0] hMax = redDim(SR, rf, rs);

	// ==========================================================
	// register port
	// read data stand only in the cycle after the strobe
	assign regRdData = rdData_reg;

	always @(posedge clk) begin
		if (srst) begin
			ctrl_reg    <= 2'b00;
			colBin_reg  <= `IGP_RST_FACTOR;
			rowBin_reg  <= `IGP_RST_FACTOR;
			colDec_reg  <= `IGP_RST_FACTOR;
			rowDec_reg  <= `IGP_RST_FACTOR;
			aoiCol_reg  <= `IGP_RST_ZERO;
			aoiRow_reg  <= `IGP_RST_ZERO;
			aoiW_reg    <= `IGP_RST_AOISIZE;
			aoiH_reg    <= `IGP_RST_AOISIZE;
			stride_reg  <= `IGP_RST_AOISIZE;
			rdData_reg  <= 16'h0000;
		end else begin
			rdData_reg <= 16'h0000;
			// writes to status and to the read-only indices fall to the default
			if (regWr) begin
				case (regAddr)
					`IGP_REG_CTRL:   ctrl_reg   <= regWrData[1:0];
					`IGP_REG_COLBIN: colBin_reg <= regWrData;
					`IGP_REG_ROWBIN: rowBin_reg <= regWrData;
					`IGP_REG_COLDEC: colDec_reg <= regWrData;
					`IGP_REG_ROWDEC: rowDec_reg <= regWrData;
					`IGP_REG_AOICOL: aoiCol_reg <= regWrData;
					`IGP_REG_AOIROW: aoiRow_reg <= regWrData;
					`IGP_REG_AOIW:   aoiW_reg   <= regWrData;
					`IGP_REG_AOIH:   aoiH_reg   <= regWrData;
					`IGP_REG_STRIDE: stride_reg <= regWrData;
					default: ;
				endcase
			end
			// a read loads the data register, which is cleared again one cycle later
			if (regRd) begin
				case (regAddr)
					`IGP_REG_CTRL:     rdData_reg <= {14'h0000, ctrl_reg};
					`IGP_REG_COLBIN:   rdData_reg <= colBin_reg;
					`IGP_REG_ROWBIN:   rdData_reg <= rowBin_reg;
					`IGP_REG_COLDEC:   rdData_reg <= colDec_reg;
					`IGP_REG_ROWDEC:   rdData_reg <= rowDec_reg;
					`IGP_REG_AOICOL:   rdData_reg <= aoiCol_reg;
					`IGP_REG_AOIROW:   rdData_reg <= aoiRow_reg;
					`IGP_REG_AOIW:     rdData_reg <= aoiW_reg;
					`IGP_REG_AOIH:     rdData_reg <= aoiH_reg;
					`IGP_REG_STRIDE:   rdData_reg <= stride_reg;
					`IGP_REG_STATUS:   rdData_reg <= {13'h0000, refused_reg, state_reg[2], state_reg[1]};
					`IGP_REG_SENSROWS: rdData_reg <= SR;
					`IGP_REG_TAPS:     rdData_reg <= SENS_TAPS;
					`IGP_REG_ADCPAR:   rdData_reg <= ADC_TAPS;
					`IGP_REG_WMAX:     rdData_reg <= wMax;
					`IGP_REG_HMAX:     rdData_reg <= hMax;
					default:           rdData_reg <= 16'h0000;
				endcase
			end
		end
	end

	// ==========================================================
	// capture: combine then subsample into the reduced frame store
	// from idle only a beat flagged as frame start is taken; others are dropped
	wire        take     = inValid & inReady;
	wire        startPix = take & (state_reg == ST_IDLE) & inFrameStart;
	wire        capPix   = take & (state_reg == ST_CAP);
	wire        doPix    = startPix | capPix;
	wire        rowEnd   = (sCol_reg == SC - 16'h0001);
	wire        frmEnd   = rowEnd & (sRow_reg == SR - 16'h0001);
	// horizontal sum; factor one passes the cell straight through
	wire [7:0]  hSum     = (cb_reg == 16'h0000) ? inData : satAdd(hAcc_reg, inData);
	wire        grpDone  = (cb_reg == cf - 16'h0001);
	wire        keepCol  = grpDone & (cd_reg == 16'h0000);
	wire        keepRow  = (rd_reg == 16'h0000) & (rRow_reg < hMax);
	wire [IW-1:0] wIdx   = memIdx(rRow_reg, rCol_reg);
	// vertical sum accumulates in place over the row group
	wire [7:0]  wData    = (rb_reg == 16'h0000) ? hSum : satAdd(frameMem[wIdx], hSum);

	// partial groups at the right or bottom edge are dropped
	always @(posedge clk) begin
		if (doPix & keepCol & keepRow & (rCol_reg < wMax))
			frameMem[wIdx] <= wData;
	end

	// position counters; the frame start pixel is forced to 0,0
	always @(posedge clk) begin
		if (srst | (state_reg == ST_IDLE)) begin
			sCol_reg <= 16'h0000;
			sRow_reg <= 16'h0000;
			cb_reg   <= 16'h0000;
			cd_reg   <= 16'h0000;
			rCol_reg <= 16'h0000;
			rb_reg   <= 16'h0000;
			rd_reg   <= 16'h0000;
			rRow_reg <= 16'h0000;
			hAcc_reg <= 8'h00;
		end
		// counters advance only on taken beats, so gaps in the stream are harmless
		if (!srst & doPix) begin
			hAcc_reg <= hSum;
			// end of a sensor row: column phases restart, row phases step
			if (rowEnd) begin
				sCol_reg <= 16'h0000;
				cb_reg   <= 16'h0000;
				cd_reg   <= 16'h0000;
				rCol_reg <= 16'h0000;
				sRow_reg <= sRow_reg + 16'h0001;
				rb_reg   <= (rb_reg == rf - 16'h0001) ? 16'h0000 : rb_reg + 16'h0001;
				if (rb_reg == rf - 16'h0001) begin
					rd_reg   <= (rd_reg == rs - 16'h0001) ? 16'h0000 : rd_reg + 16'h0001;
					if (rd_reg == 16'h0000)
						rRow_reg <= rRow_reg + 16'h0001;
				end
			end else begin
				sCol_reg <= sCol_reg + 16'h0001;
				if (grpDone) begin
					cb_reg <= 16'h0000;
					cd_reg <= (cd_reg == cs - 16'h0001) ? 16'h0000 : cd_reg + 16'h0001;
					if (cd_reg == 16'h0000)
						rCol_reg <= rCol_reg + 16'h0001;
				end else begin
					cb_reg <= cb_reg + 16'h0001;
				end
			end
		end
	end

	// ==========================================================
	// crop check against the reduced frame
	// checked once, at the last sensor pixel, so a bad crop costs a whole frame
	wire [16:0] colEnd  = {1'b0, aoiCol_reg} + {1'b0, aoiW_reg};
	wire [16:0] rowEnd2 = {1'b0, aoiRow_reg} + {1'b0, aoiH_reg};
	wire        aoiOk   = (aoiW_reg != 16'h0000) & (aoiH_reg != 16'h0000)
	                    & (colEnd <= {1'b0, wMax}) & (rowEnd2 <= {1'b0, hMax});
	wire        refSet  = doPix & frmEnd & ~aoiOk;
	wire        refClr  = regWr & (regAddr == `IGP_REG_STATUS) & regWrData[`IGP_STAT_REFUSED];

	// ==========================================================
	// readout: mirror, crop, then pad each row to the stride
	// limitation: config is read live, so change it only while idle
	// a stride below the width is read as the width
	wire [15:0] lineLen = (stride_reg > aoiW_reg) ? stride_reg : aoiW_reg;
	wire [15:0] xs      = aoiCol_reg + oCol_reg;
	wire [15:0] ys      = aoiRow_reg + oRow_reg;
	// mirroring reads the store backwards, so no second buffer is needed
	wire [15:0] srcC    = ctrl_reg[`IGP_CTRL_MIRCOL] ? wMax - 16'h0001 - xs : xs;
	wire [15:0] srcR    = ctrl_reg[`IGP_CTRL_MIRROW] ? hMax - 16'h0001 - ys : ys;
	wire        isPad   = (oCol_reg >= aoiW_reg);
	wire        lastCol = (oCol_reg == lineLen - 16'h0001);
	wire        lastRow = (oRow_reg == aoiH_reg - 16'h0001);
	// a beat is loaded when the beat register is empty or being taken
	wire        adv     = ~outValid_reg | outReady;

	assign inReady     = (state_reg == ST_IDLE) | (state_reg == ST_CAP);
	assign outValid    = outValid_reg;
	assign outData     = outData_reg;
	assign outPad      = outPad_reg;
	assign outRowStart = outRowStart_reg;
	assign outFrameEnd = outFrameEnd_reg;

	// state machine, refusal flag and output beat register
	always @(posedge clk) begin
		if (srst) begin
			state_reg       <= ST_IDLE;
			refused_reg     <= 1'b0;
			oCol_reg        <= 16'h0000;
			oRow_reg        <= 16'h0000;
			oDone_reg       <= 1'b0;
			outValid_reg    <= 1'b0;
			outPad_reg      <= 1'b0;
			outRowStart_reg <= 1'b0;
			outFrameEnd_reg <= 1'b0;
			outData_reg     <= 8'h00;
		end else begin
			// sticky until software writes a one to the refused status bit
			// a refusal in the clearing cycle still sets
			refused_reg <= refSet | (refused_reg & ~refClr);
			case (state_reg)
				ST_IDLE: begin
					if (startPix)
						state_reg <= frmEnd ? (aoiOk ? ST_OUT : ST_IDLE) : ST_CAP;
					// a one-pixel sensor jumps straight to readout, so clear here too
					oCol_reg  <= 16'h0000;
					oRow_reg  <= 16'h0000;
					oDone_reg <= 1'b0;
				end
				ST_CAP: begin
					// readout always starts from the top-left of the crop
					if (capPix & frmEnd)
						state_reg <= aoiOk ? ST_OUT : ST_IDLE;
					oCol_reg  <= 16'h0000;
					oRow_reg  <= 16'h0000;
					oDone_reg <= 1'b0;
				end
				ST_OUT: begin
					if (adv) begin
						// the last beat has been taken: drop valid and return to idle
						if (oDone_reg) begin
							outValid_reg    <= 1'b0;
							outPad_reg      <= 1'b0;
							outRowStart_reg <= 1'b0;
							outFrameEnd_reg <= 1'b0;
							state_reg       <= ST_IDLE;
						end else begin
							// next beat: a stored pixel, or a zero byte of stride padding
							outValid_reg    <= 1'b1;
							outData_reg     <= isPad ? 8'h00 : frameMem[memIdx(srcR, srcC)];
							outPad_reg      <= isPad;
							outRowStart_reg <= (oCol_reg == 16'h0000);
							outFrameEnd_reg <= lastCol & lastRow;
							if (lastCol) begin
								oCol_reg <= 16'h0000;
								oRow_reg <= oRow_reg + 16'h0001;
								oDone_reg <= lastRow;
							end else begin
								oCol_reg <= oCol_reg + 16'h0001;
							end
						end
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end
endmodule // igp_geometry_pipeline

// [rtl/igp_consts.vh]
// register map, field positions and reset values of the image geometry pipeline
`ifndef IGP_CONSTS_VH
`define IGP_CONSTS_VH
// ==========================================================
// register indices on the 4-bit register port
`define IGP_REG_CTRL      4'h0
`define IGP_REG_COLBIN    4'h1
`define IGP_REG_ROWBIN    4'h2
`define IGP_REG_COLDEC    4'h3
`define IGP_REG_ROWDEC    4'h4
`define IGP_REG_AOICOL    4'h5
`define IGP_REG_AOIROW    4'h6
`define IGP_REG_AOIW      4'h7
`define IGP_REG_AOIH      4'h8
`define IGP_REG_STRIDE    4'h9
`define IGP_REG_STATUS    4'ha
`define IGP_REG_SENSROWS  4'hb
`define IGP_REG_TAPS      4'hc
`define IGP_REG_ADCPAR    4'hd
`define IGP_REG_WMAX      4'he
`define IGP_REG_HMAX      4'hf
// ==========================================================
// field positions
`define IGP_CTRL_MIRCOL   0
`define IGP_CTRL_MIRROW   1
`define IGP_STAT_CAPBUSY  0
`define IGP_STAT_OUTBUSY  1
`define IGP_STAT_REFUSED  2
// ==========================================================
// tap count encodings
`define IGP_TAPS_ONE      16'h0000
`define IGP_TAPS_TWO      16'h0001
`define IGP_TAPS_THREE    16'h0002
`define IGP_TAPS_FOUR     16'h0003
`define IGP_TAPS_EIGHT    16'h0004
`define IGP_TAPS_TEN      16'h0005
`define IGP_TAPS_DEVSPEC  16'h0006
// ==========================================================
// reset values
`define IGP_RST_FACTOR    16'h0001
`define IGP_RST_AOISIZE   16'h0010
`define IGP_RST_ZERO      16'h0000
`endif

// [verification/igp_checker_sva.sv]
// port assertions of the image geometry pipeline
`timescale 1ns/1ps
module igp_checker #(
	parameter [15:0] SENS_ROWS = 16'h0030,
	parameter [15:0] SENS_TAPS = 16'h0000,
	parameter [15:0] ADC_TAPS  = 16'h0000
) (
	input wire        clk,
	input wire        srst,
	input wire [3:0]  regAddr,
	input wire        regRd,
	input wire [15:0] regRdData,
	input wire        inReady,
	input wire        outValid,
	input wire [7:0]  outData,
	input wire        outPad,
	input wire        outRowStart,
	input wire        outFrameEnd,
	input wire        outReady
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// ==========================================================
	// register port: read data only after a read
	read_idle_zero_a: assert property (!regRd |=> regRdData == 16'h0000) else $error("read data without read");
	sensor_rows_a: assert property (regRd && regAddr == 4'hb |=> regRdData == SENS_ROWS) else $error("row count");
	tap_code_a: assert property (regRd && regAddr == 4'hc |=> regRdData == SENS_TAPS) else $error("tap code");
	adc_code_a: assert property (regRd && regAddr == 4'hd |=> regRdData == ADC_TAPS) else $error("adc code");
	// ==========================================================
	// output stream: beats hold, pads are blank, capture waits
	beat_hold_a: assert property (outValid && !outReady |=>
		outValid && $stable({outData, outPad, outRowStart, outFrameEnd})) else $error("beat dropped");
	pad_blank_a: assert property (outValid && outPad |-> outData == 8'h00 && !outRowStart) else $error("pad");
	no_capture_a: assert property (outValid |-> !inReady) else $error("capture during readout");
	frame_done_a: assert property (outValid && outReady && outFrameEnd |=> !outValid && inReady)
		else $error("no idle after frame");
endmodule // igp_checker

// [verification/igp_sensor_model.sv]
// sensor readout model feeding one raster frame per start pulse
`timescale 1ns/1ps
module igp_sensor_model #(
	parameter COLS = 8,
	parameter ROWS = 4
) (
	input  wire       clk,
	input  wire       go,
	input  wire       inReady,
	output reg        inValid,
	output reg        inFrameStart,
	output reg  [7:0] inData
);
	integer n = COLS * ROWS;
	// ==========================================================
	// cell (x,y) carries y*16+x; one idle cycle after every beat taken
	initial begin
		inValid = 1'b0;
		inFrameStart = 1'b0;
		inData = 8'h00;
	end
	always @(posedge clk) begin
		if (go) begin
			n <= 1;
			inValid <= 1'b1;
			inFrameStart <= 1'b1;
			inData <= 8'h00;
		end else if (inValid && inReady) begin
			inValid <= 1'b0;
			inFrameStart <= 1'b0;
			inData <= ~inData; // released line shows no stale value
		end else if (!inValid && n < COLS * ROWS) begin
			inValid <= 1'b1;
			inData <= 8'((n / COLS) * 16 + n % COLS);
			n <= n + 1;
		end
	end
endmodule // igp_sensor_model

// [verification/igp_geometry_pipeline_tb.sv]
// self-checking bench of the image geometry pipeline
`timescale 1ns/1ps
`include "igp_consts.vh"
module igp_geometry_pipeline_tb;
	localparam COLS = 8;
	localparam ROWS = 4;
	reg         clk = 1'b0;
	reg         srst = 1'b1;
	reg  [3:0]  regAddr = 4'h0;
	reg  [15:0] regWrData = 16'h0000;
	reg         regWr = 1'b0;
	reg         regRd = 1'b0;
	reg         outReady = 1'b1;
	reg         go = 1'b0;
	reg         stall = 1'b0;
	wire [15:0] regRdData;
	wire [7:0]  inData, outData;
	wire        inValid, inFrameStart, inReady, outValid, outPad, outRowStart, outFrameEnd;
	integer     nFail = 0;
	integer     testsRun = 0;
	integer     cyc = 0;
	reg  [10:0] seen[$];
	always #50 clk = ~clk;
	igp_geometry_pipeline #(.SENS_COLS(COLS), .SENS_ROWS(ROWS), .SENS_TAPS(`IGP_TAPS_FOUR),
		.ADC_TAPS(`IGP_TAPS_TWO)) igp_geometry_pipeline_i (.clk(clk), .srst(srst), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .inValid(inValid),
		.inFrameStart(inFrameStart), .inData(inData), .inReady(inReady), .outValid(outValid),
		.outData(outData), .outPad(outPad), .outRowStart(outRowStart), .outFrameEnd(outFrameEnd),
		.outReady(outReady));
	igp_sensor_model #(.COLS(COLS), .ROWS(ROWS)) igp_sensor_model_i (.clk(clk), .go(go), .inReady(inReady),
		.inValid(inValid), .inFrameStart(inFrameStart), .inData(inData));
	// ==========================================================
	// sink: stalls every third cycle when asked, records accepted beats
	always @(posedge clk) begin
		cyc <= cyc + 1;
		outReady <= !(stall && cyc % 3 == 0);
		if (outValid && outReady)
			seen.push_back({outPad, outRowStart, outFrameEnd, outData});
	end
	task summarize;
		begin
			if (nFail == 0 && testsRun > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	task chk(input [15:0] got, input [15:0] exp);
		begin
			testsRun = testsRun + 1;
			if (got !== exp) begin
				nFail = nFail + 1;
				$display("BAD t=%0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// write then one spare edge, so strobes never toggle twice in a step
	task wr(input [3:0] a, input [15:0] d);
		begin
			regAddr <= a;
			regWrData <= d;
			regWr <= 1'b1;
			@(posedge clk);
			regWr <= 1'b0;
			@(posedge clk);
		end
	endtask
	task rdc(input [3:0] a, input [15:0] exp);
		begin
			regAddr <= a;
			regRd <= 1'b1;
			@(posedge clk);
			regRd <= 1'b0;
			@(posedge clk);
			chk(regRdData, exp);
		end
	endtask
	// one frame: program, capture, compare stream against the reduced-frame model
	task frame(input integer cb, rb, cs, rs, ox, oy, w, h, st, mir, s);
		integer wm, hm, x, y, i, j, c, r, v, k, rl;
		reg [10:0] e;
		begin
			wm = ((COLS / cb) + cs - 1) / cs;
			hm = ((ROWS / rb) + rs - 1) / rs;
			wr(4'h1, cb[15:0]);
			wr(4'h2, rb[15:0]);
			wr(4'h3, cs[15:0]);
			wr(4'h4, rs[15:0]);
			wr(4'h5, ox[15:0]);
			wr(4'h6, oy[15:0]);
			wr(4'h7, w[15:0]);
			wr(4'h8, h[15:0]);
			wr(4'h9, st[15:0]);
			wr(4'h0, mir[15:0]);
			rdc(4'he, wm[15:0]);
			rdc(4'hf, hm[15:0]);
			seen.delete();
			stall <= s[0];
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			for (k = 0; k < 300 && !(seen.size() > 0 && seen[seen.size() - 1][8]); k++)
				@(posedge clk);
			stall <= 1'b0;
			k = 0;
			rl = (st > w) ? st : w;
			for (y = 0; y < h && w > 0 && ox + w <= wm && oy + h <= hm; y++)
				for (x = 0; x < rl; x++) begin
					c = mir[0] ? wm - 1 - (ox + x) : ox + x;
					r = mir[1] ? hm - 1 - (oy + y) : oy + y;
					v = 0;
					for (i = 0; i < cb; i++)
						for (j = 0; j < rb; j++)
							v = v + (r * rs * rb + j) * 16 + c * cs * cb + i;
					e = {x >= w, x == 0, y == h - 1 && x == rl - 1, x >= w ? 8'h00 : (v > 255 ? 8'hff : v[7:0])};
					chk({5'h00, (k < seen.size()) ? seen[k] : 11'h7ff}, {5'h00, e});
					k = k + 1;
				end
			chk(16'(seen.size()), k[15:0]);
			rdc(4'ha, (k == 0) ? 16'h0004 : 16'h0000);
			wr(4'ha, 16'h0004);
			rdc(4'ha, 16'h0000);
		end
	endtask
	// ==========================================================
	// watchdog
	initial begin
		#(100 * 40000);
		nFail = nFail + 1;
		summarize;
	end
	// ==========================================================
	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rdc(4'h1, 16'h0001);
		rdc(4'h2, 16'h0001);
		rdc(4'h3, 16'h0001);
		rdc(4'h4, 16'h0001);
		rdc(4'h7, 16'h0010);
		rdc(4'h8, 16'h0010);
		rdc(4'h9, 16'h0010);
		rdc(4'hb, ROWS);
		rdc(4'hc, `IGP_TAPS_FOUR);
		rdc(4'hd, `IGP_TAPS_TWO);
		wr(4'hd, 16'h0005);
		rdc(4'hd, `IGP_TAPS_TWO);
		frame(1, 1, 1, 1, 0, 0, 16, 16, 16, 0, 0);
		frame(1, 1, 1, 1, 1, 1, 3, 2, 4, 0, 1);
		frame(2, 2, 1, 1, 0, 0, 4, 2, 4, 1, 0);
		frame(1, 1, 2, 2, 1, 1, 2, 1, 6, 2, 1);
		frame(1, 1, 1, 1, 7, 3, 1, 1, 0, 3, 0);
		frame(1, 1, 1, 1, 1, 0, 8, 1, 8, 0, 0);
		frame(1, 1, 1, 1, 0, 0, 0, 1, 4, 0, 0);
		frame(4, 4, 1, 1, 0, 0, 2, 1, 4, 0, 0);
		// reset in mid-capture: defaults return and the next frame is clean
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (6) @(posedge clk);
		rdc(4'ha, 16'h0001);
		srst <= 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		repeat (60) @(posedge clk);
		rdc(4'ha, 16'h0000);
		rdc(4'h1, 16'h0001);
		rdc(4'h7, 16'h0010);
		frame(1, 1, 1, 1, 2, 1, 2, 2, 4, 0, 0);
		summarize;
	end
endmodule // igp_geometry_pipeline_tb
bind igp_geometry_pipeline igp_checker #(.SENS_ROWS(SENS_ROWS), .SENS_TAPS(SENS_TAPS), .ADC_TAPS(ADC_TAPS)) chk_i (
	.clk(clk), .srst(srst), .regAddr(regAddr), .regRd(regRd), .regRdData(regRdData), .inReady(inReady),
	.outValid(outValid), .outData(outData), .outPad(outPad), .outRowStart(outRowStart),
	.outFrameEnd(outFrameEnd), .outReady(outReady));
